// ---- pkg/sfr_pkg.sv ----
// Constants, opcodes and state types of the serial flash read host
package sfr_pkg;

  ////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_MHZ = 40;
  localparam int T_RST_US = 10;
  localparam int T_REC_US = 1;
  localparam int T_XFR_US = 200;
  localparam int RST_CYC = T_RST_US * CLK_MHZ;
  localparam int REC_CYC = T_REC_US * CLK_MHZ;
  localparam int XFR_CYC = T_XFR_US * CLK_MHZ;
  localparam int TMR_W = 16;
  // Half period of the serial clock in system clocks
  localparam logic [3:0] SCK_HALF = 4'h3;
  // Chip select high time between frames
  localparam logic [3:0] CS_GAP = 4'h4;

  ////////////////////////////////////////////////////////////////////
  // Read opcodes
  localparam logic [7:0] OP_CONT_LEGACY = 8'hE8;
  localparam logic [7:0] OP_CONT_FAST = 8'h0B;
  localparam logic [7:0] OP_CONT_LOW = 8'h01;
  localparam logic [7:0] OP_CONT_STD = 8'h03;
  localparam logic [7:0] OP_PAGE_RD = 8'hD2;
  localparam logic [7:0] OP_BUF1_RD = 8'hD4;
  localparam logic [7:0] OP_BUF2_RD = 8'hD6;
  localparam logic [7:0] OP_BUF1_LF = 8'hD1;
  localparam logic [7:0] OP_BUF2_LF = 8'hD3;
  localparam logic [7:0] OP_SPROT_RD = 8'h32;
  localparam logic [7:0] OP_LOCK_RD = 8'h35;
  localparam logic [7:0] OP_SEC_RD = 8'h77;
  localparam logic [7:0] OP_STAT_RD = 8'hD7;
  localparam logic [7:0] OP_ID_RD = 8'h9F;
  localparam logic [7:0] FILL_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////
  // Header lengths in bytes, opcode included
  localparam logic [3:0] HDR_OP = 4'h1;
  localparam logic [3:0] HDR_A = 4'h4;
  localparam logic [3:0] HDR_A_D1 = 4'h5;
  localparam logic [3:0] HDR_A_D4 = 4'h8;

  ////////////////////////////////////////////////////////////////////
  // Geometry and rewrite tracking
  localparam int PAGE_W = 12;
  localparam int BYTE_W = 9;
  localparam int ADDR_W = 24;
  localparam int LEN_W = 16;
  localparam int TOT_W = 17;
  localparam int PAGE_COUNT = 4096;
  localparam int REWRITE_SPAN = 50000;

  ////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    CL_NONE, CL_CONT_D4, CL_CONT_D1, CL_CONT_D0, CL_PAGE,
    CL_BUF, CL_BUF_LF, CL_REG_A, CL_REG_OP, CL_XFR
  } sfr_class_e;

  typedef enum logic [2:0] {
    E_IDLE = 3'b000, E_LOW = 3'b001, E_HIGH = 3'b011,
    E_TAIL = 3'b010, E_GAP = 3'b110
  } sfr_eng_e;

  typedef enum logic [2:0] {
    M_RST = 3'b000, M_REC = 3'b001, M_IDLE = 3'b011,
    M_SEND = 3'b010, M_DRAIN = 3'b110, M_XFR = 3'b111
  } sfr_main_e;

endpackage

// ---- pkg/sfr_byte_if.sv ----
// Byte stream carrier between the command sequencer and the serial engine
`timescale 1ns/1ps
interface sfr_byte_if;
  logic tx_valid;
  logic tx_ready;
  logic tx_last;
  logic [7:0] tx_data;
  logic rx_valid;
  logic [7:0] rx_data;
  logic busy;
  modport ctrl (output tx_valid, output tx_last, output tx_data,
                input tx_ready, input rx_valid, input rx_data, input busy);
  modport engine (input tx_valid, input tx_last, input tx_data,
                  output tx_ready, output rx_valid, output rx_data, output busy);
endinterface

// ---- core/sfr_spi_engine.sv ----
// Serial byte engine: clock divider, chip select framing and bit shifting
`timescale 1ns/1ps
module sfr_spi_engine (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sfr_byte_if.engine bus,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  import sfr_pkg::*;

  sfr_eng_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic last_reg, last_next;
  logic sck_reg, sck_next;
  logic cs_n_reg, cs_n_next;
  logic rx_valid_reg, rx_valid_next;
  logic miso_m_reg, miso_s_reg;

  wire tick = (cnt_reg == 4'h0);
  wire byte_end = tick && (bit_reg == 3'h7);
  wire rx_bit = miso_s_reg;

  ////////////////////////////////////////////////////////////////////
  assign bus.tx_ready = (state_reg == E_IDLE) ||
                        ((state_reg == E_HIGH) && byte_end && !last_reg);
  assign bus.rx_valid = rx_valid_reg;
  assign bus.rx_data = rx_data_reg;
  assign bus.busy = (state_reg != E_IDLE);
  assign sck_o = sck_reg;
  assign cs_n_o = cs_n_reg;
  assign mosi_o = tx_sh_reg[7];

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cnt_next = tick ? cnt_reg : cnt_reg - 4'h1;
    bit_next = bit_reg;
    tx_sh_next = tx_sh_reg;
    rx_sh_next = rx_sh_reg;
    rx_data_next = rx_data_reg;
    last_next = last_reg;
    sck_next = sck_reg;
    cs_n_next = cs_n_reg;
    rx_valid_next = 1'b0;
    unique case (state_reg)
      E_IDLE: begin
        if (bus.tx_valid) begin
          tx_sh_next = bus.tx_data;
          last_next = bus.tx_last;
          cs_n_next = 1'b0;
          bit_next = 3'h0;
          cnt_next = SCK_HALF - 4'h1;
          state_next = E_LOW;
        end
      end
      E_LOW: begin
        // Rising edge: sample the device bit driven on the last fall
        if (tick) begin
          sck_next = 1'b1;
          rx_sh_next = {rx_sh_reg[6:0], rx_bit};
          if (bit_reg == 3'h7) begin
            rx_valid_next = 1'b1;
            rx_data_next = {rx_sh_reg[6:0], rx_bit};
          end
          cnt_next = SCK_HALF - 4'h1;
          state_next = E_HIGH;
        end
      end
      E_HIGH: begin
        // Falling edge: present the next host bit
        if (tick && (bit_reg != 3'h7)) begin
          sck_next = 1'b0;
          tx_sh_next = {tx_sh_reg[6:0], 1'b0};
          bit_next = bit_reg + 3'h1;
          cnt_next = SCK_HALF - 4'h1;
          state_next = E_LOW;
        end else if (byte_end && last_reg) begin
          sck_next = 1'b0;
          cnt_next = SCK_HALF - 4'h1;
          state_next = E_TAIL;
        end else if (byte_end && bus.tx_valid) begin
          // Clock parks high while the next byte is late
          sck_next = 1'b0;
          tx_sh_next = bus.tx_data;
          last_next = bus.tx_last;
          bit_next = 3'h0;
          cnt_next = SCK_HALF - 4'h1;
          state_next = E_LOW;
        end
      end
      E_TAIL: begin
        if (tick) begin
          cs_n_next = 1'b1;
          cnt_next = CS_GAP - 4'h1;
          state_next = E_GAP;
        end
      end
      E_GAP: begin
        if (tick) begin
          state_next = E_IDLE;
        end
      end
      default: begin
        state_next = E_IDLE;
        cs_n_next = 1'b1;
        sck_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    miso_m_reg <= miso_i;
    miso_s_reg <= miso_m_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= E_IDLE;
      cnt_reg <= 4'h0;
      bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      last_reg <= 1'b0;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      rx_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      rx_data_reg <= rx_data_next;
      last_reg <= last_next;
      sck_reg <= sck_next;
      cs_n_reg <= cs_n_next;
      rx_valid_reg <= rx_valid_next;
    end
  end
endmodule // sfr_spi_engine

// ---- core/sfr_host.sv ----
// Host controller issuing read commands to a serial flash with two buffers
`timescale 1ns/1ps
module sfr_host #(
  parameter logic [7:0] P2B_BUF1_OP = 8'hFE,
  parameter logic [7:0] P2B_BUF2_OP = 8'hFF,
  parameter int XFR_WAIT_CYC = sfr_pkg::XFR_CYC,
  parameter int REWRITE_OPS = sfr_pkg::REWRITE_SPAN
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  output logic SCK_O,
  output logic CS_N_O,
  output logic MOSI_O,
  input wire logic MISO_I,
  output logic FLASH_RST_N_O,
  input wire logic PAGE_256_I,
  input wire logic CMD_VALID_I,
  input wire logic [7:0] CMD_OP_I,
  input wire logic [sfr_pkg::PAGE_W-1:0] CMD_PAGE_I,
  input wire logic [sfr_pkg::BYTE_W-1:0] CMD_BYTE_I,
  input wire logic [sfr_pkg::LEN_W-1:0] CMD_LEN_I,
  output logic CMD_READY_O,
  output logic CMD_ERR_O,
  output logic CMD_DONE_O,
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  input wire logic PGM_OP_I,
  input wire logic REWRITE_DONE_I,
  output logic REWRITE_DUE_O,
  output logic [sfr_pkg::PAGE_W-1:0] REWRITE_PAGE_O
);
  import sfr_pkg::*;

  // Spread over the whole array: every page comes due within the span
  localparam int REWRITE_GAP = REWRITE_OPS / PAGE_COUNT;

  ////////////////////////////////////////////////////////////////////
  // Opcode decoding
  function automatic sfr_class_e op_class(input logic [7:0] op);
    sfr_class_e c;
    c = CL_NONE;
    if (op == OP_CONT_LEGACY) c = CL_CONT_D4;
    if (op == OP_CONT_FAST) c = CL_CONT_D1;
    if (op == OP_CONT_LOW || op == OP_CONT_STD) c = CL_CONT_D0;
    if (op == OP_PAGE_RD) c = CL_PAGE;
    if (op == OP_BUF1_RD || op == OP_BUF2_RD) c = CL_BUF;
    if (op == OP_BUF1_LF || op == OP_BUF2_LF) c = CL_BUF_LF;
    if (op == OP_SPROT_RD) c = CL_REG_A;
    if (op == OP_LOCK_RD) c = CL_REG_A;
    if (op == OP_SEC_RD) c = CL_REG_A;
    if (op == OP_STAT_RD) c = CL_REG_OP;
    if (op == OP_ID_RD) c = CL_REG_OP;
    if (op == P2B_BUF1_OP || op == P2B_BUF2_OP) c = CL_XFR;
    return c;
  endfunction

  function automatic logic [3:0] hdr_len(input sfr_class_e c);
    logic [3:0] n;
    n = HDR_A;
    if (c == CL_CONT_D4 || c == CL_PAGE) n = HDR_A_D4;
    if (c == CL_CONT_D1 || c == CL_BUF) n = HDR_A_D1;
    if (c == CL_REG_OP) n = HDR_OP;
    return n;
  endfunction

  function automatic logic has_addr(input sfr_class_e c);
    return (c != CL_REG_A) && (c != CL_REG_OP);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations
  sfr_byte_if bus ();

  sfr_main_e state_reg, state_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [7:0] op_reg, op_next;
  sfr_class_e cls_reg, cls_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [3:0] hdr_reg, hdr_next;
  logic [TOT_W-1:0] total_reg, total_next;
  logic [TOT_W-1:0] sent_reg, sent_next;
  logic [TOT_W-1:0] rxc_reg, rxc_next;
  logic flash_rst_n_reg, flash_rst_n_next;
  logic page256_reg, page256_next;
  logic strap_m_reg, strap_s_reg;
  logic err_reg, done_reg, done_next;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic [LEN_W-1:0] opcnt_reg, opcnt_next;
  logic due_reg, due_next;
  logic [PAGE_W-1:0] ptr_reg, ptr_next;

  ////////////////////////////////////////////////////////////////////
  // Command intake and address forming
  wire ready = (state_reg == M_IDLE);
  wire accept = CMD_VALID_I && ready;
  sfr_class_e cls_in;
  assign cls_in = op_class(CMD_OP_I);
  wire known = (cls_in != CL_NONE);
  wire [3:0] hdr_in = hdr_len(cls_in);
  wire [ADDR_W-1:0] addr_264 = {3'h0, CMD_PAGE_I, CMD_BYTE_I};
  wire [ADDR_W-1:0] addr_256 = {4'h0, CMD_PAGE_I, CMD_BYTE_I[7:0]};
  wire [ADDR_W-1:0] addr_sel = page256_reg ? addr_256 : addr_264;
  wire [ADDR_W-1:0] addr_in = has_addr(cls_in) ? addr_sel : '0;
  wire is_xfr = (cls_in == CL_XFR);
  wire [TOT_W-1:0] len_in = is_xfr ? '0 : TOT_W'(CMD_LEN_I);
  wire [TOT_W-1:0] total_in = TOT_W'(hdr_in) + len_in;

  ////////////////////////////////////////////////////////////////////
  // Byte stream towards the engine
  wire [7:0] tx_byte = (sent_reg == TOT_W'(0)) ? op_reg :
                       (sent_reg == TOT_W'(1)) ? addr_reg[23:16] :
                       (sent_reg == TOT_W'(2)) ? addr_reg[15:8] :
                       (sent_reg == TOT_W'(3)) ? addr_reg[7:0] : FILL_BYTE;
  wire tx_last = (sent_reg == total_reg - TOT_W'(1));
  wire take = bus.tx_valid && bus.tx_ready;
  wire rx_keep = bus.rx_valid && (rxc_reg >= TOT_W'(hdr_reg));

  assign bus.tx_valid = (state_reg == M_SEND);
  assign bus.tx_data = tx_byte;
  assign bus.tx_last = tx_last;

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_next = state_reg;
    tmr_next = (tmr_reg == '0) ? tmr_reg : tmr_reg - TMR_W'(1);
    op_next = op_reg;
    cls_next = cls_reg;
    addr_next = addr_reg;
    hdr_next = hdr_reg;
    total_next = total_reg;
    sent_next = take ? sent_reg + TOT_W'(1) : sent_reg;
    rxc_next = bus.rx_valid ? rxc_reg + TOT_W'(1) : rxc_reg;
    flash_rst_n_next = flash_rst_n_reg;
    page256_next = page256_reg;
    done_next = 1'b0;
    unique case (state_reg)
      M_RST: begin
        // Engine sits idle here, so select is high at release
        if (tmr_reg == '0) begin
          flash_rst_n_next = 1'b1;
          tmr_next = TMR_W'(REC_CYC - 1);
          state_next = M_REC;
        end
      end
      M_REC: begin
        if (tmr_reg == '0) begin
          page256_next = strap_s_reg;
          state_next = M_IDLE;
        end
      end
      M_IDLE: begin
        // Unknown opcodes never reach the pins
        if (accept && known) begin
          op_next = CMD_OP_I;
          cls_next = cls_in;
          addr_next = addr_in;
          hdr_next = hdr_in;
          total_next = total_in;
          sent_next = '0;
          rxc_next = '0;
          state_next = M_SEND;
        end
      end
      M_SEND: begin
        if (take && tx_last) begin
          state_next = M_DRAIN;
        end
      end
      M_DRAIN: begin
        if (!bus.busy && cls_reg == CL_XFR) begin
          // Device needs the full copy time before the buffer is usable
          tmr_next = TMR_W'(XFR_WAIT_CYC - 1);
          state_next = M_XFR;
        end else if (!bus.busy) begin
          done_next = 1'b1;
          state_next = M_IDLE;
        end
      end
      M_XFR: begin
        if (tmr_reg == '0) begin
          done_next = 1'b1;
          state_next = M_IDLE;
        end
      end
      default: begin
        state_next = M_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Rewrite pacing: a new due flag wins over a same-cycle acknowledge
  wire op_hit = PGM_OP_I && (opcnt_reg == LEN_W'(REWRITE_GAP - 1));
  wire ack = REWRITE_DONE_I && due_reg;

  always_comb begin
    opcnt_next = opcnt_reg;
    if (op_hit) begin
      opcnt_next = '0;
    end else if (PGM_OP_I) begin
      opcnt_next = opcnt_reg + LEN_W'(1);
    end
    due_next = op_hit || (due_reg && !REWRITE_DONE_I);
    ptr_next = ack ? ptr_reg + PAGE_W'(1) : ptr_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge MCLK_I) begin
    strap_m_reg <= PAGE_256_I;
    strap_s_reg <= strap_m_reg;
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state_reg <= M_RST;
      tmr_reg <= TMR_W'(RST_CYC - 1);
      op_reg <= 8'h00;
      cls_reg <= CL_NONE;
      addr_reg <= '0;
      hdr_reg <= 4'h0;
      total_reg <= '0;
      sent_reg <= '0;
      rxc_reg <= '0;
      flash_rst_n_reg <= 1'b0;
      page256_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      op_reg <= op_next;
      cls_reg <= cls_next;
      addr_reg <= addr_next;
      hdr_reg <= hdr_next;
      total_reg <= total_next;
      sent_reg <= sent_next;
      rxc_reg <= rxc_next;
      flash_rst_n_reg <= flash_rst_n_next;
      page256_reg <= page256_next;
      done_reg <= done_next;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      err_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
    end else begin
      err_reg <= accept && !known;
      rd_valid_reg <= rx_keep;
      rd_data_reg <= rx_keep ? bus.rx_data : rd_data_reg;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      opcnt_reg <= '0;
      due_reg <= 1'b0;
      ptr_reg <= '0;
    end else begin
      opcnt_reg <= opcnt_next;
      due_reg <= due_next;
      ptr_reg <= ptr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial engine
  sfr_spi_engine u_engine (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .bus(bus),
    .sck_o(SCK_O),
    .cs_n_o(CS_N_O),
    .mosi_o(MOSI_O),
    .miso_i(MISO_I)
  );

  assign FLASH_RST_N_O = flash_rst_n_reg;
  assign CMD_READY_O = ready;
  assign CMD_ERR_O = err_reg;
  assign CMD_DONE_O = done_reg;
  assign RD_DATA_O = rd_data_reg;
  assign RD_VALID_O = rd_valid_reg;
  assign REWRITE_DUE_O = due_reg;
  assign REWRITE_PAGE_O = ptr_reg;

endmodule // sfr_host

// ---- sim/sfr_flash_model.sv ----
// Behavioural serial flash answering read, register and transfer frames
`timescale 1ns/1ps
module sfr_flash_model (
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic rst_n_i,
  output logic miso_o
);
  logic [7:0] hdr [0:3];
  logic [7:0] rx_sr;
  logic [7:0] tx_sr;
  int bit_n = 0;
  int nbytes = 0;
  int frames = 0;
  initial miso_o = 1'b0;
  // Reply byte n is the opcode XOR n (byte 0 is zero), so a wrong header length shows in the data
  function automatic logic [7:0] reply(input int n);
    return (n == 0) ? 8'h00 : hdr[0] ^ 8'(n);
  endfunction
  always @(negedge cs_n_i) begin
    if (rst_n_i) begin
      bit_n = 0;
      nbytes = 0;
      tx_sr = reply(0);
      miso_o <= tx_sr[7];
    end
  end
  always @(posedge sck_i) begin
    if (!cs_n_i && rst_n_i) begin
      rx_sr = {rx_sr[6:0], mosi_i};
      bit_n++;
      if (bit_n == 8) begin
        if (nbytes < 4)
          hdr[nbytes] = rx_sr;
        nbytes++;
        bit_n = 0;
      end
    end
  end
  always @(negedge sck_i) begin
    if (!cs_n_i && rst_n_i) begin
      tx_sr = (bit_n == 0) ? reply(nbytes) : {tx_sr[6:0], 1'b0};
      miso_o <= tx_sr[7];
    end
  end
  // Released line has no pull: show the inverse so a late sample is caught
  always @(posedge cs_n_i) begin
    if (rst_n_i)
      frames++;
    miso_o <= ~miso_o;
  end
endmodule // sfr_flash_model

// ---- sim/sfr_host_chk.sv ----
// Checker of the read host port behaviour
`timescale 1ns/1ps
module sfr_host_chk #(
  parameter logic [7:0] P2B_BUF1_OP = 8'hFE,
  parameter logic [7:0] P2B_BUF2_OP = 8'hFF,
  parameter int XFR_WAIT_CYC = 8000,
  parameter int REWRITE_OPS = 50000
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic SCK_O,
  input wire logic CS_N_O,
  input wire logic MOSI_O,
  input wire logic FLASH_RST_N_O,
  input wire logic CMD_VALID_I,
  input wire logic [7:0] CMD_OP_I,
  input wire logic CMD_READY_O,
  input wire logic CMD_ERR_O,
  input wire logic CMD_DONE_O,
  input wire logic PGM_OP_I,
  input wire logic REWRITE_DONE_I,
  input wire logic REWRITE_DUE_O,
  input wire logic [sfr_pkg::PAGE_W-1:0] REWRITE_PAGE_O
);
  import sfr_pkg::*;
  localparam int GAP = REWRITE_OPS / PAGE_COUNT;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  //////////////////////////////////////////////////////////////////////
  wire logic take = CMD_VALID_I && CMD_READY_O;
  wire logic is_xfr = (CMD_OP_I == P2B_BUF1_OP) || (CMD_OP_I == P2B_BUF2_OP);
  wire logic known = is_xfr || (CMD_OP_I inside {OP_CONT_LEGACY, OP_CONT_FAST, OP_CONT_LOW,
    OP_CONT_STD, OP_PAGE_RD, OP_BUF1_RD, OP_BUF2_RD, OP_BUF1_LF, OP_BUF2_LF, OP_SPROT_RD,
    OP_LOCK_RD, OP_SEC_RD, OP_STAT_RD, OP_ID_RD});
  wire logic op_msb = CMD_OP_I[7];
  logic [15:0] ops_reg;
  logic [15:0] hi_reg;
  logic xfr_reg;
  // High-time count clears on every frame, so it measures the wait after select rises
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      ops_reg <= 16'h0000;
      hi_reg <= 16'h0000;
      xfr_reg <= 1'b0;
    end else begin
      if (PGM_OP_I)
        ops_reg <= (ops_reg == 16'(GAP - 1)) ? 16'h0000 : ops_reg + 16'h0001;
      hi_reg <= CS_N_O ? hi_reg + 16'h0001 : 16'h0000;
      if (take)
        xfr_reg <= is_xfr;
    end
  end
  //////////////////////////////////////////////////////////////////////
  property p_rst_cs;
    $rose(FLASH_RST_N_O) |-> CS_N_O && $past(CS_N_O);
  endproperty
  a_rst_cs: assert property (p_rst_cs) else $error("select low at reset release");
  property p_sck_idle;
    CS_N_O |-> !SCK_O;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock high outside frame");
  property p_sck_high;
    $rose(SCK_O) |-> SCK_O [*3] ##1 !SCK_O;
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("clock high time wrong");
  property p_mosi_hold;
    SCK_O |-> $stable(MOSI_O);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
  property p_unknown;
    take && !known |=> CMD_ERR_O && CS_N_O ##1 CS_N_O;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown opcode not refused");
  property p_known;
    take && known |=> !CMD_ERR_O ##1 !CS_N_O;
  endproperty
  a_known: assert property (p_known) else $error("known opcode not started");
  property p_first_bit;
    take && known |=> ##1 MOSI_O == $past(op_msb, 2);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit not opcode msb");
  property p_xfr_wait;
    CMD_DONE_O && xfr_reg |-> hi_reg >= 16'(XFR_WAIT_CYC - 1);
  endproperty
  a_xfr_wait: assert property (p_xfr_wait) else $error("transfer done too early");
  property p_due_set;
    PGM_OP_I && ops_reg == 16'(GAP - 1) |-> ##[1:2] REWRITE_DUE_O;
  endproperty
  a_due_set: assert property (p_due_set) else $error("rewrite not flagged");
  property p_ptr_inc;
    REWRITE_DONE_I && REWRITE_DUE_O |=> REWRITE_PAGE_O == $past(REWRITE_PAGE_O) + 1'b1;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");
  c_xfr: cover property (take && is_xfr);
  c_err: cover property (CMD_ERR_O);
  c_due: cover property ($rose(REWRITE_DUE_O));
endmodule // sfr_host_chk

bind sfr_host sfr_host_chk #(
  .P2B_BUF1_OP(P2B_BUF1_OP),
  .P2B_BUF2_OP(P2B_BUF2_OP),
  .XFR_WAIT_CYC(XFR_WAIT_CYC),
  .REWRITE_OPS(REWRITE_OPS)
) u_chk (
  .MCLK_I, .RST_N_I, .SCK_O, .CS_N_O, .MOSI_O, .FLASH_RST_N_O, .CMD_VALID_I, .CMD_OP_I,
  .CMD_READY_O, .CMD_ERR_O, .CMD_DONE_O, .PGM_OP_I, .REWRITE_DONE_I, .REWRITE_DUE_O,
  .REWRITE_PAGE_O
);

// ---- sim/tb.sv ----
// Testbench: read host against a behavioural serial flash
`timescale 1ns/1ps
module tb;
  import sfr_pkg::*;
  localparam logic [7:0] OP_X1 = 8'h53;
  localparam logic [7:0] OP_X2 = 8'h55;
  localparam int XW = 20;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic p256 = 1'b0;
  logic vld = 1'b0;
  logic pgm = 1'b0;
  logic rw_done = 1'b0;
  logic [7:0] op = 8'h00;
  logic [PAGE_W-1:0] pg = 12'hA5C;
  logic [BYTE_W-1:0] by = 9'h1B3;
  logic [LEN_W-1:0] len = 16'h0000;
  wire logic sck, cs_n, mosi, miso, frst_n, rdy, err, done, rdv, due;
  wire logic [7:0] rdd;
  wire logic [PAGE_W-1:0] rpage;
  int num_errors = 0;
  int total_checks = 0;
  int cycle = 0;
  always #12.5 mclk = ~mclk;
  // Transfers are shortened so the run stays short
  sfr_host #(.P2B_BUF1_OP(OP_X1), .P2B_BUF2_OP(OP_X2), .XFR_WAIT_CYC(XW),
    .REWRITE_OPS(8192)) u_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .SCK_O(sck),
    .CS_N_O(cs_n), .MOSI_O(mosi), .MISO_I(miso), .FLASH_RST_N_O(frst_n),
    .PAGE_256_I(p256), .CMD_VALID_I(vld), .CMD_OP_I(op), .CMD_PAGE_I(pg),
    .CMD_BYTE_I(by), .CMD_LEN_I(len), .CMD_READY_O(rdy), .CMD_ERR_O(err),
    .CMD_DONE_O(done), .RD_DATA_O(rdd), .RD_VALID_O(rdv), .PGM_OP_I(pgm),
    .REWRITE_DONE_I(rw_done), .REWRITE_DUE_O(due), .REWRITE_PAGE_O(rpage));
  sfr_flash_model u_flash (.sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .rst_n_i(frst_n),
    .miso_o(miso));
  always @(posedge mclk) begin
    cycle <= cycle + 1;
    if (cycle == 60000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(input logic strap);
    int n;
    @(posedge mclk);
    rst_n <= 1'b0;
    p256 <= strap;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    n = 0;
    while (rdy !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      if (frst_n === 1'b0)
        check(cs_n, 1'b1);
      n++;
    end
    check(n > RST_CYC + REC_CYC && rdy === 1'b1, 1'b1);
    check(frst_n, 1'b1);
  endtask
  // One command: header bytes, address and returned data judged here
  task automatic run_cmd(input logic [7:0] o, input int hl, input logic zadr,
    input logic [15:0] n);
    logic [7:0] got[$];
    logic [23:0] adr;
    logic xfr;
    int k;
    int f0;
    int c0;
    xfr = (o == OP_X1) || (o == OP_X2);
    f0 = u_flash.frames;
    c0 = cycle;
    @(posedge mclk);
    // Page and byte settle before the expected address is formed
    adr = zadr ? 24'h0 : (p256 ? {4'h0, pg, by[7:0]} : {3'h0, pg, by});
    vld <= 1'b1;
    op <= o;
    len <= n;
    @(posedge mclk);
    vld <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      if (rdv === 1'b1)
        got.push_back(rdd);
      if (cs_n === 1'b0)
        c0 = cycle;
      k++;
    end
    check(done, 1'b1);
    check(u_flash.frames, f0 + 1);
    check(u_flash.nbytes, hl + (xfr ? 0 : n));
    check(u_flash.hdr[0], o);
    if (hl >= 4)
      check({u_flash.hdr[1], u_flash.hdr[2], u_flash.hdr[3]}, adr);
    check(got.size(), xfr ? 0 : n);
    foreach (got[i])
      check(got[i], o ^ 8'(hl + i));
    if (xfr)
      check(cycle - c0 >= XW, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_cont();
    run_cmd(OP_CONT_LEGACY, 8, 1'b0, 16'h3);
    run_cmd(OP_CONT_FAST, 5, 1'b0, 16'h2);
    run_cmd(OP_CONT_LOW, 4, 1'b0, 16'h1);
    run_cmd(OP_CONT_STD, 4, 1'b0, 16'h2);
    $display("test cont_read done");
  endtask
  task automatic t_page_buf();
    run_cmd(OP_PAGE_RD, 8, 1'b0, 16'h2);
    run_cmd(OP_BUF1_RD, 5, 1'b0, 16'h2);
    run_cmd(OP_BUF2_RD, 5, 1'b0, 16'h1);
    run_cmd(OP_BUF1_LF, 4, 1'b0, 16'h2);
    run_cmd(OP_BUF2_LF, 4, 1'b0, 16'h1);
    $display("test page_buf done");
  endtask
  task automatic t_regs();
    run_cmd(OP_SPROT_RD, 4, 1'b1, 16'h2);
    run_cmd(OP_LOCK_RD, 4, 1'b1, 16'h2);
    run_cmd(OP_SEC_RD, 4, 1'b1, 16'h3);
    run_cmd(OP_STAT_RD, 1, 1'b1, 16'h1);
    run_cmd(OP_ID_RD, 1, 1'b1, 16'h3);
    run_cmd(OP_ID_RD, 1, 1'b1, 16'h0);
    $display("test regs done");
  endtask
  task automatic t_unknown();
    int f0;
    f0 = u_flash.frames;
    @(posedge mclk);
    vld <= 1'b1;
    op <= 8'h5A;
    @(posedge mclk);
    vld <= 1'b0;
    @(negedge mclk);
    check(err, 1'b1);
    repeat (20) @(negedge mclk);
    check(u_flash.frames, f0);
    $display("test unknown done");
  endtask
  task automatic t_xfr();
    @(posedge mclk);
    by <= 9'h0FF;
    run_cmd(OP_X1, 4, 1'b0, 16'h5);
    run_cmd(OP_X2, 4, 1'b0, 16'h0);
    $display("test transfer done");
  endtask
  task automatic t_page256();
    do_reset(1'b1);
    @(posedge mclk);
    pg <= 12'hFFF;
    run_cmd(OP_PAGE_RD, 8, 1'b0, 16'h1);
    run_cmd(OP_BUF2_RD, 5, 1'b0, 16'h1);
    $display("test page256 done");
  endtask
  task automatic t_rewrite();
    @(posedge mclk);
    rw_done <= 1'b1;
    @(posedge mclk);
    rw_done <= 1'b0;
    pgm <= 1'b1;
    @(negedge mclk);
    check(rpage, 12'h000);
    @(posedge mclk);
    @(negedge mclk);
    check(due, 1'b0);
    @(posedge mclk);
    pgm <= 1'b0;
    @(negedge mclk);
    check(due, 1'b1);
    @(posedge mclk);
    rw_done <= 1'b1;
    @(posedge mclk);
    rw_done <= 1'b0;
    repeat (2) @(negedge mclk);
    check({due, rpage}, 13'h0001);
    $display("test rewrite done");
  endtask
  initial begin
    do_reset(1'b0);
    t_rewrite();
    t_cont();
    t_page_buf();
    t_regs();
    t_unknown();
    t_xfr();
    t_page256();
    tally_and_finish();
  end
endmodule // tb
